// *** logic/dhps_pkg.sv ***
// package of constants for the dual slot hot-plug sequencer
package dhps_pkg;
    // timing clock
    localparam int unsigned CLK_HZ          = 25000000;
    // times in their own units
    localparam int unsigned RESET_DELAY_MS  = 100;
    localparam int unsigned DEBOUNCE_MS     = 5;
    localparam int unsigned SETTLE_MS       = 5;
    localparam int unsigned RETRY_MS        = 1500;
    // cycle counts, clock per millisecond rounded down, then scaled by the time
    localparam int unsigned RESET_DELAY_CYC = (CLK_HZ / 1000) * RESET_DELAY_MS;
    localparam int unsigned DEBOUNCE_CYC    = (CLK_HZ / 1000) * DEBOUNCE_MS;
    localparam int unsigned SETTLE_CYC      = (CLK_HZ / 1000) * SETTLE_MS;
    localparam int unsigned RETRY_CYC       = (CLK_HZ / 1000) * RETRY_MS;
    localparam int unsigned CNT_W           = 26;
    localparam int unsigned SLOTS           = 2;

    // per-slot sequencer states
    typedef enum logic [3:0] {
        DHPS_OFF   = 4'h1,
        DHPS_WAIT  = 4'h2,
        DHPS_ON    = 4'h4,
        DHPS_FAULT = 4'h8
    } dhps_state_e;
endpackage : dhps_pkg

// *** logic/dhps_sequencer.sv ***
// dual slot hot-plug power sequencer control logic
//
// Overview of operation
// R1 - a switched-off slot connects discharge switches on its main output rails
// R2 - slot over-temperature shuts that slot off and asserts its fault only
// R3 - die over-temperature shuts both slots off regardless of force-on
// R4 - power-ok asserted only while slot enabled and all three rails above threshold
// R5 - reset release held low at least 100 ms after rails good; after a rail dropout in DHPS_ON the code drives it high with no delay
// R6 - reset driven low at once whenever slot power disabled
// R7 - force-on turns on all rails, ignores faults, hides power-ok and fault
// R8 - standby undervoltage lockout stays effective during force-on
// R9 - attention inputs debounced 5 ms drive open-drain attention outputs
// R10 - recovery-select low retries every 1.5 s; high latches off after fault
// R11 - aux rail turned on only while card-present is low
// R12 - commands ignored while card absent and 5 ms after it appears
// R13 - unconnected control inputs read high and therefore inactive
// R14 - latch mode clears by cycling the enable of the faulted rail group
// R15 - regulation timer expiry turns slot off and drives fault low
// R16 - severe overcurrent on a main rail shuts outputs at once
// R17 - all intervals counted on the free clock, one counter set per slot
// R18 - analogue indications synchronised through two flops before use
`timescale 1ns/10ps
module dhps_sequencer (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       standby_undervoltage_lockout, // high while standby rail too low
    input  wire logic       die_overtemp,                 // async, whole die
    input  wire logic       recovery_select_n,            // low = retry, high/open = latch
    input  wire logic [1:0] card_present_n,               // low = card seated
    input  wire logic [1:0] main_enable_n,
    input  wire logic [1:0] aux_rail_enable_n,
    input  wire logic [1:0] force_on_n,
    input  wire logic [1:0] slot_overtemp,                // async
    input  wire logic [1:0] main_uv_ok,                   // async, both main rails above threshold
    input  wire logic [1:0] aux_uv_ok,                    // async
    input  wire logic [1:0] main_regulation_expired,      // async, timer reached limit
    input  wire logic [1:0] aux_regulation_expired,       // async
    input  wire logic [1:0] main_severe_overcurrent,      // async
    input  wire logic [1:0] attention_input,              // async
    output logic      [1:0] main_rail_on,
    output logic      [1:0] aux_rail_on,
    output logic      [1:0] main_discharge_on,
    output logic      [1:0] slot_power_ok_n,
    output logic      [1:0] slot_reset_n,
    output logic      [1:0] slot_fault_n,
    output logic      [1:0] attention_output_oe            // open drain: high pulls low
);

    // ******************************************************************
    // input synchronisers
    // ******************************************************************
    localparam int unsigned NS = 25;
    logic [NS-1:0] async_in;
    logic [NS-1:0] sync1;
    logic [NS-1:0] sync2;

    assign async_in = {standby_undervoltage_lockout, die_overtemp, recovery_select_n,
                       card_present_n, main_enable_n, aux_rail_enable_n, force_on_n,
                       slot_overtemp, main_uv_ok, aux_uv_ok, main_regulation_expired,
                       aux_regulation_expired, main_severe_overcurrent, attention_input};

    // two flops; only sync2 is read (R18)
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1 <= {NS{1'b0}};
            sync2 <= {NS{1'b0}};
        end else begin
            sync1 <= async_in; // R18
            sync2 <= sync1;
        end
    end

    logic       s_uvlo, s_die_ot, s_latch_mode;
    logic [1:0] s_abs, s_main_cmd, s_aux_cmd, s_force, s_slot_ot, s_main_ok, s_aux_ok;
    logic [1:0] s_main_exp, s_aux_exp, s_woc, s_att;
    logic [1:0] s_prs_n, s_men_n, s_aen_n, s_fon_n;

    // pulled-up inputs read high = inactive; commands are active low (R13)
    assign {s_uvlo, s_die_ot, s_latch_mode, s_prs_n, s_men_n, s_aen_n, s_fon_n, s_slot_ot,
            s_main_ok, s_aux_ok, s_main_exp, s_aux_exp, s_woc, s_att} = sync2;
    assign s_abs      = s_prs_n;  // R13
    assign s_main_cmd = ~s_men_n;
    assign s_aux_cmd  = ~s_aen_n;
    assign s_force    = ~s_fon_n;

    // ******************************************************************
    // per-slot sequencing
    // ******************************************************************
    dhps_pkg::dhps_state_e       state      [2];
    dhps_pkg::dhps_state_e       next_state [2];
    logic [dhps_pkg::CNT_W-1:0]  tmr        [2];
    logic [dhps_pkg::CNT_W-1:0]  next_tmr   [2];
    logic [dhps_pkg::CNT_W-1:0]  settle     [2];
    logic [dhps_pkg::CNT_W-1:0]  next_settle[2];
    logic [dhps_pkg::CNT_W-1:0]  deb        [2];
    logic [dhps_pkg::CNT_W-1:0]  next_deb   [2];
    logic [1:0] att_val, next_att_val;
    logic [1:0] m_flt, a_flt, next_m_flt, next_a_flt;
    logic [1:0] m_cmd_d, a_cmd_d;
    logic [1:0] cmd_ok, slot_en, forced, rails_good;

    function automatic logic [dhps_pkg::CNT_W-1:0] cnt_up(
        input logic [dhps_pkg::CNT_W-1:0] v, input int unsigned lim);
        cnt_up = (v >= dhps_pkg::CNT_W'(lim)) ? v : v + 1'b1;
    endfunction

    // next-state logic for both slots (R17)
    always_comb begin
        for (int i = 0; i < dhps_pkg::SLOTS; i++) begin
            next_state[i]   = state[i];
            next_tmr[i]     = tmr[i];
            next_m_flt[i]   = m_flt[i];
            next_a_flt[i]   = a_flt[i];
            // presence settling gate (R12)
            next_settle[i]  = s_abs[i] ? '0 : cnt_up(settle[i], dhps_pkg::SETTLE_CYC);
            cmd_ok[i]       = !s_abs[i] && settle[i] >= dhps_pkg::CNT_W'(dhps_pkg::SETTLE_CYC);
            // die over-temperature overrides force-on as well
            forced[i]       = cmd_ok[i] && s_force[i] && !s_uvlo && !s_die_ot; // R3 R7 R8
            slot_en[i]      = cmd_ok[i] && (s_main_cmd[i] || s_aux_cmd[i]) && !s_uvlo;
            rails_good[i]   = s_main_ok[i] && s_aux_ok[i];
            // debounce: value moves only after steady input (R9)
            next_att_val[i] = att_val[i];
            if (s_att[i] == att_val[i]) begin
                next_deb[i] = '0;
            end else if (deb[i] >= dhps_pkg::CNT_W'(dhps_pkg::DEBOUNCE_CYC - 1)) begin
                next_deb[i]     = '0;
                next_att_val[i] = s_att[i]; // R9
            end else begin
                next_deb[i] = deb[i] + 1'b1;
            end
            // latch-mode clear by releasing the faulted group's enable (R14)
            if (m_cmd_d[i] && !s_main_cmd[i]) next_m_flt[i] = 1'b0; // R14
            if (a_cmd_d[i] && !s_aux_cmd[i]) next_a_flt[i] = 1'b0; // R14
            case (state[i])
                dhps_pkg::DHPS_OFF: begin
                    next_tmr[i] = '0;
                    if (slot_en[i] && !m_flt[i] && !a_flt[i] && !s_die_ot)
                        next_state[i] = dhps_pkg::DHPS_WAIT;
                end
                dhps_pkg::DHPS_WAIT, dhps_pkg::DHPS_ON: begin
                    // reset delay counts from rails good (R5)
                    next_tmr[i] = rails_good[i] ? cnt_up(tmr[i], dhps_pkg::RESET_DELAY_CYC) : '0;
                    if (state[i] == dhps_pkg::DHPS_WAIT &&
                        tmr[i] >= dhps_pkg::CNT_W'(dhps_pkg::RESET_DELAY_CYC))
                        next_state[i] = dhps_pkg::DHPS_ON; // R5
                    if (!slot_en[i]) next_state[i] = dhps_pkg::DHPS_OFF; // R6
                    if (!forced[i] && (s_slot_ot[i] || s_main_exp[i] || s_woc[i] ||
                                       s_aux_exp[i])) begin // R2 R15 R16
                        next_state[i] = dhps_pkg::DHPS_FAULT;
                        next_tmr[i]   = '0;
                        next_m_flt[i] = s_slot_ot[i] | s_main_exp[i] | s_woc[i];
                        next_a_flt[i] = s_slot_ot[i] | s_aux_exp[i];
                    end
                    if (s_die_ot) next_state[i] = dhps_pkg::DHPS_OFF; // R3
                end
                dhps_pkg::DHPS_FAULT: begin
                    next_tmr[i] = cnt_up(tmr[i], dhps_pkg::RETRY_CYC);
                    if (!s_latch_mode && tmr[i] >= dhps_pkg::CNT_W'(dhps_pkg::RETRY_CYC)) begin
                        next_state[i] = dhps_pkg::DHPS_OFF; // R10
                        next_m_flt[i] = 1'b0;
                        next_a_flt[i] = 1'b0;
                    end else if (s_latch_mode && !next_m_flt[i] && !next_a_flt[i]) begin
                        next_state[i] = dhps_pkg::DHPS_OFF; // R10 R14
                    end
                end
                default: next_state[i] = dhps_pkg::DHPS_OFF;
            endcase
        end
    end

    // state registers
    always_ff @(posedge clk) begin
        for (int i = 0; i < dhps_pkg::SLOTS; i++) begin
            if (rst) begin
                state[i]  <= dhps_pkg::DHPS_OFF;
                tmr[i]    <= '0;
                settle[i] <= '0;
                deb[i]    <= '0;
            end else begin
                state[i]  <= next_state[i];
                tmr[i]    <= next_tmr[i];
                settle[i] <= next_settle[i];
                deb[i]    <= next_deb[i];
            end
        end
        if (rst) begin
            att_val <= 2'h0;
            m_flt   <= 2'h0;
            a_flt   <= 2'h0;
            m_cmd_d <= 2'h0;
            a_cmd_d <= 2'h0;
        end else begin
            att_val <= next_att_val;
            m_flt   <= next_m_flt;
            a_flt   <= next_a_flt;
            m_cmd_d <= s_main_cmd;
            a_cmd_d <= s_aux_cmd;
        end
    end

    // ******************************************************************
    // outputs
    // ******************************************************************
    logic [1:0] run;
    always_comb begin
        for (int i = 0; i < dhps_pkg::SLOTS; i++) begin
            run[i] = (state[i] == dhps_pkg::DHPS_WAIT || state[i] == dhps_pkg::DHPS_ON) &&
                     !s_die_ot && !s_uvlo;
        end
    end

    // rail drive, discharge, status (registered)
    always_ff @(posedge clk) begin
        if (rst) begin
            main_rail_on        <= 2'h0;
            aux_rail_on         <= 2'h0;
            main_discharge_on   <= 2'h3;
            slot_power_ok_n     <= 2'h3;
            slot_reset_n        <= 2'h0;
            slot_fault_n        <= 2'h3;
            attention_output_oe <= 2'h0;
        end else begin
            for (int i = 0; i < dhps_pkg::SLOTS; i++) begin
                main_rail_on[i] <= forced[i] || (run[i] && s_main_cmd[i]); // R7 R8
                aux_rail_on[i]  <= !s_abs[i] && (forced[i] || (run[i] && s_aux_cmd[i])); // R11
                main_discharge_on[i] <= !(forced[i] || (run[i] && s_main_cmd[i])); // R1
                slot_power_ok_n[i] <= !(!forced[i] && run[i] && rails_good[i]); // R4 R7
                slot_reset_n[i] <= !forced[i] && run[i] &&
                                   state[i] == dhps_pkg::DHPS_ON && rails_good[i]; // R5 R6
                slot_fault_n[i] <= forced[i] || state[i] != dhps_pkg::DHPS_FAULT; // R2 R15
                attention_output_oe[i] <= !att_val[i]; // R9
            end
        end
    end

    // ******************************************************************
    // assertions and covers
    // ******************************************************************
    // a main rail is either switched on or discharged
    AST_DISCHARGE: assert property (@(posedge clk) disable iff (rst) // R1
        (main_rail_on | main_discharge_on) == 2'h3)
        else $error("main rail neither on nor discharged");
    // slot over-temperature moves a running slot to fault
    AST_SLOT_OT: assert property (@(posedge clk) disable iff (rst) // R2
        run[0] && s_slot_ot[0] && !forced[0] && !s_die_ot |=>
        state[0] == dhps_pkg::DHPS_FAULT)
        else $error("slot over-temperature did not fault the slot");
    // fault state shows on the fault output unless forced
    AST_FAULT_OUT: assert property (@(posedge clk) disable iff (rst) // R15
        state[1] == dhps_pkg::DHPS_FAULT && !forced[1] |=> !slot_fault_n[1])
        else $error("fault state without fault output");
    // die over-temperature removes every rail of both slots
    AST_DIE_OT: assert property (@(posedge clk) disable iff (rst) // R3
        s_die_ot |=> (main_rail_on | aux_rail_on) == 2'h0)
        else $error("rail on during die over-temperature");
    // standby lockout removes every rail, even under force-on
    AST_UVLO: assert property (@(posedge clk) disable iff (rst) // R8
        s_uvlo |=> (main_rail_on | aux_rail_on) == 2'h0)
        else $error("rail on during standby lockout");
    // force-on hides power-ok and fault
    AST_FORCE_HIDES: assert property (@(posedge clk) disable iff (rst) // R7
        ($past(forced) & ~(slot_power_ok_n & slot_fault_n)) == 2'h0)
        else $error("status shown during force-on");
    // aux rail stays off without a seated card
    AST_AUX_PRESENT: assert property (@(posedge clk) disable iff (rst) // R11
        (aux_rail_on & $past(s_abs)) == 2'h0)
        else $error("aux rail on without card");
    // reset output low once the slot is disabled
    AST_RESET_DROP: assert property (@(posedge clk) disable iff (rst) // R6
        !slot_en[0] |-> ##2 !slot_reset_n[0])
        else $error("reset output high after disable");

    COV_FORCED: cover property (@(posedge clk) disable iff (rst)
        forced[0] && main_rail_on[0]);
    COV_FAULT: cover property (@(posedge clk) disable iff (rst)
        !slot_fault_n[1]);
    COV_POWER_OK: cover property (@(posedge clk) disable iff (rst)
        slot_power_ok_n != 2'h3);

endmodule // dhps_sequencer

// *** tb/dhps_card_model.sv ***
// add-in card model: presence contact and rail monitors
`timescale 1ns/10ps
module dhps_card_model (
    input  wire logic       clk,
    input  wire logic [1:0] main_rail_on,
    input  wire logic [1:0] aux_rail_on,
    output logic      [1:0] card_present_n,
    output logic      [1:0] main_uv_ok,
    output logic      [1:0] aux_uv_ok
);
    // both cards seated from power-up, presence contact pulled low
    assign card_present_n = 2'h0;
    // rails report above threshold one cycle after their switch closes
    always_ff @(posedge clk) begin
        main_uv_ok <= main_rail_on;
        aux_uv_ok  <= aux_rail_on;
    end
endmodule // dhps_card_model

// *** tb/testbench.sv ***
// self-checking bench for the dual slot hot-plug sequencer
`timescale 1ns/10ps
`define DHPS_CHK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
module testbench;
    logic clk = 0, rst = 1, uvlo = 0, die = 0, probe = 0;
    logic [1:0] men_n = 2'h3, aen_n = 2'h3, fon_n = 2'h3, sot = 2'h0, att = 2'h0;
    logic [1:0] mexp = 2'h0;
    logic [1:0] cp_n, muv, auv, mon, aon, dis, pok_n, rs_n, flt_n, oe;
    logic [13:0] exp_q[$];
    logic [13:0] e;
    int failures = 0, checked = 0, seed = 95297;
    wire [13:0] obs = {mon, aon, dis, pok_n, rs_n, flt_n, oe};

    // ********************************************
    // clock, design and card
    // ********************************************
    always #20 clk = ~clk;
    dhps_sequencer dut (.clk(clk), .rst(rst), .standby_undervoltage_lockout(uvlo),
        .die_overtemp(die), .recovery_select_n(1'b1), .card_present_n(cp_n),
        .main_enable_n(men_n), .aux_rail_enable_n(aen_n), .force_on_n(fon_n),
        .slot_overtemp(sot), .main_uv_ok(muv), .aux_uv_ok(auv),
        .main_regulation_expired(mexp), .aux_regulation_expired(2'h0),
        .main_severe_overcurrent(2'h0), .attention_input(att), .main_rail_on(mon),
        .aux_rail_on(aon), .main_discharge_on(dis), .slot_power_ok_n(pok_n),
        .slot_reset_n(rs_n), .slot_fault_n(flt_n), .attention_output_oe(oe));
    dhps_card_model card (.clk(clk), .main_rail_on(mon), .aux_rail_on(aon),
        .card_present_n(cp_n), .main_uv_ok(muv), .aux_uv_ok(auv));

    // ********************************************
    // note taking, checking and verdict
    // ********************************************
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // queue an expected output set and flag the monitor for the next edge
    task automatic note(input logic [13:0] x);
        exp_q.push_back(x);
        probe <= 1'b1;
        @(posedge clk);
        probe <= 1'b0;
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // compare the oldest note with the outputs when flagged
    always @(posedge clk) begin
        if (probe) begin
            e = exp_q.pop_front();
            `DHPS_CHK("outputs", e, obs)
        end
    end
    // watchdog sized past settle time plus the scenarios
    initial begin
        #(40 * 150000);
        failures++;
        results();
    end

    // ********************************************
    // scenarios
    // ********************************************
    initial begin
        wt(12);
        rst <= 1'b0;
        note({2'h0, 2'h0, 2'h3, 2'h3, 2'h0, 2'h3, 2'h0});
        men_n <= 2'h0;
        aen_n <= 2'h0;
        // short random bursts on one attention input must be filtered
        repeat (200) begin
            att[1] <= 1'($random(seed));
            @(posedge clk);
        end
        att[1] <= 1'b1;
        wt(800);
        note({2'h0, 2'h0, 2'h3, 2'h3, 2'h0, 2'h3, 2'h3});
        wt(dhps_pkg::SETTLE_CYC);
        note({2'h3, 2'h3, 2'h0, 2'h0, 2'h0, 2'h3, 2'h1});
        sot <= 2'h2;
        wt(10);
        note({2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h1, 2'h1});
        sot <= 2'h0;
        wt(10);
        note({2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h1, 2'h1});
        men_n <= 2'h2;
        aen_n <= 2'h2;
        wt(10);
        men_n <= 2'h0;
        aen_n <= 2'h0;
        wt(10);
        note({2'h3, 2'h3, 2'h0, 2'h0, 2'h0, 2'h3, 2'h1});
        die <= 1'b1;
        wt(10);
        note({2'h0, 2'h0, 2'h3, 2'h3, 2'h0, 2'h3, 2'h1});
        die <= 1'b0;
        uvlo <= 1'b1;
        fon_n <= 2'h2;
        wt(10);
        note({2'h0, 2'h0, 2'h3, 2'h3, 2'h0, 2'h3, 2'h1});
        uvlo <= 1'b0;
        wt(10);
        note({2'h3, 2'h3, 2'h0, 2'h1, 2'h0, 2'h3, 2'h1});
        // regulation timer expiry faults slot 1, forced slot 0 ignores it
        mexp <= 2'h3;
        wt(10);
        note({2'h1, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h1});
        wt(2);
        results();
    end
endmodule // testbench
